// ---- rtl/mpfb_filter_binding.sv ----
`include "mpfb_cfg.svh"

module mpfb_filter_binding
  import mpfb_pkg::*;
#(
  parameter int SHARED_ENTRIES = 11
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // management register port (page-addressed 16-bit words)
  input wire logic [9:0] regPage,
  input wire logic [6:0] regNum,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // frame from the receive parser
  input wire logic frameValid,
  input wire mpfb_frame_s frameInfo,
  // verdict to the receive path
  output mpfb_verdict_s verdict,
  output logic verdictValid
);

  if (SHARED_ENTRIES < 1 || SHARED_ENTRIES > 11) begin : g_chk
    $error("SHARED_ENTRIES must be 1 to 11");
  end

  // a writable read-only bit would let software bind dhcpv6 or a reserved bit
  localparam logic [31:0] BIND_RO_HIT =
    (`MPFB_BIND_WMASK | `MPFB_BIND_RST) & `MPFB_BIND_RO_MASK;
  if (BIND_RO_HIT != 32'h00000000) begin : g_chk_ro
    $error("binding bits 0-8, 11, 13 and 30 must stay read-only zero");
  end

  logic [31:0] bindWord_r;
  logic [31:0] bindWord_nxt;
  logic [15:0] shrEnable_r;
  logic [15:0] shrEnable_nxt;
  logic [31:0] mgmtV4Addr_r;
  logic [31:0] mgmtV4Addr_nxt;
  logic [23:0] low24Value_r;
  logic [23:0] low24Value_nxt;
  logic [15:0] regRdData_r;
  logic regRdValid_r;
  mpfb_verdict_s verdict_r;
  mpfb_verdict_s verdict_nxt;
  logic verdictValid_r;

  // register decode
  wire pageHit = (regPage == `MPFB_PAGE);
  wire selBindLo = pageHit && (regNum == `MPFB_REG_BIND_LO);
  wire selBindHi = pageHit && (regNum == `MPFB_REG_BIND_HI);
  wire selShrEn = pageHit && (regNum == `MPFB_REG_SHR_EN);
  wire selV4Lo = pageHit && (regNum == `MPFB_REG_V4_LO);
  wire selV4Hi = pageHit && (regNum == `MPFB_REG_V4_HI);
  wire selL24Lo = pageHit && (regNum == `MPFB_REG_LOW24_LO);
  wire selL24Hi = pageHit && (regNum == `MPFB_REG_LOW24_HI);

  // read-only and reserved bits hold their reset value on writes
  wire [31:0] bindWrLo = {bindWord_r[31:16], regWrData};
  wire [31:0] bindWrHi = {regWrData, bindWord_r[15:0]};
  wire [31:0] bindWrSel = selBindLo ? bindWrLo : bindWrHi;
  wire [31:0] bindMasked = (bindWrSel & `MPFB_BIND_WMASK)
                         | (`MPFB_BIND_RST & ~`MPFB_BIND_WMASK);
  assign bindWord_nxt = (regWrEn && (selBindLo || selBindHi))
                      ? bindMasked : bindWord_r;

  assign shrEnable_nxt = (regWrEn && selShrEn)
                       ? (regWrData & `MPFB_SHR_EN_WMASK) : shrEnable_r;

  // low byte of the address is the first byte on the wire
  assign mgmtV4Addr_nxt = !regWrEn ? mgmtV4Addr_r
                        : selV4Lo ? {mgmtV4Addr_r[31:16], regWrData}
                        : selV4Hi ? {regWrData, mgmtV4Addr_r[15:0]}
                        : mgmtV4Addr_r;

  assign low24Value_nxt = !regWrEn ? low24Value_r
                        : selL24Lo ? {low24Value_r[23:16], regWrData}
                        : selL24Hi ? {regWrData[7:0], low24Value_r[15:0]}
                        : low24Value_r;

  // unmapped registers of the page read as zero
  wire [15:0] rdMux = selBindLo ? bindWord_r[15:0]
                    : selBindHi ? bindWord_r[31:16]
                    : selShrEn ? shrEnable_r
                    : selV4Lo ? mgmtV4Addr_r[15:0]
                    : selV4Hi ? mgmtV4Addr_r[31:16]
                    : selL24Lo ? low24Value_r[15:0]
                    : selL24Hi ? {8'h00, low24Value_r[23:16]}
                    : 16'h0000;

  // low24 address compare, only meaningful on ipv6 frames
  wire low24Match = frameInfo.isIpv6
                  && (frameInfo.ipv6Low24 == low24Value_r);

  // raw hits laid out on the binding bit positions
  logic [31:0] rawHit;
  always_comb begin
    rawHit = 32'h00000000;
    rawHit[`MPFB_B_TCP9] = frameInfo.tcpPort9Hit;
    rawHit[`MPFB_B_TCP10] = frameInfo.tcpPort10Hit;
    rawHit[`MPFB_B_UDP0] = frameInfo.udpPort0Hit;
    rawHit[`MPFB_B_DHCP6] = frameInfo.dhcp6Hit;
    rawHit[`MPFB_B_EAPUDP] = frameInfo.eapUdpHit;
    rawHit[`MPFB_B_NAMELU] = frameInfo.nameLookupHit;
    rawHit[`MPFB_B_FLEX0 +: 12] = frameInfo.flexPortHit;
    rawHit[`MPFB_B_RANGE] = frameInfo.portRangeHit;
    rawHit[`MPFB_B_ICMP6] = frameInfo.icmp6Hit;
    rawHit[`MPFB_B_RMCP] = frameInfo.rmcpHit;
  end

  // one gate per binding bit: a set bit adds the low24 condition,
  // a clear bit lets the raw hit through untouched
  logic [31:0] boundPass;
  for (genvar b = 0; b < 32; b++) begin : g_bind
    assign boundPass[b] = rawHit[b]
                        && (!bindWord_r[b] || low24Match);
  end

  // shared address routing, unimplemented entries never route
  logic [10:0] shrRoute;
  for (genvar e = 0; e < 11; e++) begin : g_shr
    if (e < SHARED_ENTRIES) begin : g_on
      assign shrRoute[e] = shrEnable_r[e]
                         && frameInfo.addrValidFlag[e]
                         && frameInfo.sharedAddrHit[e];
    end else begin : g_off
      assign shrRoute[e] = 1'b0;
    end
  end

  // frames are compared against the address as stored, so the parser
  // must present the destination with its first wire byte in bits 7:0
  wire v4Match = (frameInfo.ipv4Dest == mgmtV4Addr_r);
  wire v4Req = v4Match && (frameInfo.isArp || frameInfo.isIpv4Req);
  wire v4Wake = v4Match && !frameInfo.isArp;

  always_comb begin
    verdict_nxt = verdict_r;
    if (frameValid) begin
      verdict_nxt.passVec = boundPass;
      verdict_nxt.sharedAddrRoute = shrRoute;
      verdict_nxt.toMgmtController = |shrRoute;
      verdict_nxt.v4RequestHit = v4Req;
      verdict_nxt.v4WakeHit = v4Wake;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bindWord_r <= `MPFB_BIND_RST;
      shrEnable_r <= `MPFB_SHR_EN_RST;
      mgmtV4Addr_r <= `MPFB_V4_RST;
      low24Value_r <= `MPFB_LOW24_RST;
    end else begin
      bindWord_r <= bindWord_nxt;
      shrEnable_r <= shrEnable_nxt;
      mgmtV4Addr_r <= mgmtV4Addr_nxt;
      low24Value_r <= low24Value_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      regRdData_r <= 16'h0000;
      regRdValid_r <= 1'b0;
      verdict_r <= '0;
      verdictValid_r <= 1'b0;
    end else begin
      regRdData_r <= regRdEn ? rdMux : regRdData_r;
      regRdValid_r <= regRdEn;
      verdict_r <= verdict_nxt;
      verdictValid_r <= frameValid;
    end
  end

  assign regRdData = regRdData_r;
  assign regRdValid = regRdValid_r;
  assign verdict = verdict_r;
  assign verdictValid = verdictValid_r;

endmodule

// ---- common/mpfb_cfg.svh ----
`ifndef MPFB_CFG_SVH
`define MPFB_CFG_SVH

// register page and register numbers inside that page
`define MPFB_PAGE 10'h321
`define MPFB_REG_LOW24_LO 7'h2c
`define MPFB_REG_LOW24_HI 7'h2d
`define MPFB_REG_BIND_LO 7'h32
`define MPFB_REG_BIND_HI 7'h33
`define MPFB_REG_SHR_EN 7'h34
`define MPFB_REG_V4_LO 7'h50
`define MPFB_REG_V4_HI 7'h51

// writable bits of the binding word: 9,10,12,14..29,31
`define MPFB_BIND_WMASK 32'hbfffd600
// bits that never take a write: 0..8 unbuilt, 11, 13 and 30
`define MPFB_BIND_RO_MASK 32'h400029ff
`define MPFB_BIND_RST 32'h00000000
`define MPFB_SHR_EN_WMASK 16'h07ff
`define MPFB_SHR_EN_RST 16'h0000
`define MPFB_V4_RST 32'h00000000
`define MPFB_LOW24_RST 24'h000000

// binding bit positions
`define MPFB_B_TCP9 9
`define MPFB_B_TCP10 10
`define MPFB_B_UDP0 12
`define MPFB_B_DHCP6 13
`define MPFB_B_EAPUDP 14
`define MPFB_B_NAMELU 15
`define MPFB_B_FLEX0 16
`define MPFB_B_RANGE 28
`define MPFB_B_ICMP6 29
`define MPFB_B_RMCP 31

`endif

// ---- common/mpfb_pkg.sv ----
package mpfb_pkg;

  // raw filter hits and header fields of one received frame
  typedef struct packed {
    logic tcpPort9Hit;
    logic tcpPort10Hit;
    logic udpPort0Hit;
    logic dhcp6Hit;
    logic eapUdpHit;
    logic nameLookupHit;
    logic [11:0] flexPortHit;
    logic portRangeHit;
    logic icmp6Hit;
    logic rmcpHit;
    logic isIpv6;
    logic [23:0] ipv6Low24;
    logic [10:0] sharedAddrHit;
    logic [10:0] addrValidFlag;
    logic isArp;
    logic isIpv4Req;
    logic [31:0] ipv4Dest;
  } mpfb_frame_s;

  // filter verdicts after binding
  typedef struct packed {
    logic [31:0] passVec;
    logic toMgmtController;
    logic [10:0] sharedAddrRoute;
    logic v4RequestHit;
    logic v4WakeHit;
  } mpfb_verdict_s;

endpackage

// ---- sim/mpfb_filter_binding_chk.sv ----
module mpfb_filter_binding_chk
  import mpfb_pkg::*;
#(
  parameter int SHARED_ENTRIES = 11
) (
  // clock and reset
  input logic sys_clk,
  input logic reset_n,
  // register port
  input logic regRdEn,
  input logic regRdValid,
  // frame and verdict
  input logic frameValid,
  input mpfb_frame_s frameInfo,
  input mpfb_verdict_s verdict,
  input logic verdictValid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  rd_answer_a: assert property (regRdValid == $past(regRdEn))
    else $error("read answer not one edge after strobe");
  verdict_pulse_a: assert property (frameValid |=> verdictValid)
    else $error("verdict not one edge after frame");
  verdict_hold_a: assert property (!frameValid |=> $stable(verdict))
    else $error("verdict moved without a frame");
  rsv_clear_a: assert property (verdictValid |->
    verdict.passVec[8:0] == 0 && !verdict.passVec[11] && !verdict.passVec[30])
    else $error("reserved pass bit set");
  route_sum_a: assert property (verdictValid |->
    verdict.toMgmtController == (|verdict.sharedAddrRoute))
    else $error("controller route disagrees with entries");
  route_cause_a: assert property (frameValid |=>
    (verdict.sharedAddrRoute &
    ~$past(frameInfo.sharedAddrHit & frameInfo.addrValidFlag)) == 0)
    else $error("route without valid hit");
  arp_wake_a: assert property (frameValid && frameInfo.isArp
    |=> !verdict.v4WakeHit) else $error("wake on arp frame");
  req_kind_a: assert property (frameValid && !frameInfo.isArp &&
    !frameInfo.isIpv4Req |=> !verdict.v4RequestHit)
    else $error("request hit on non request");
  rmcp_pass_a: assert property (frameValid && !frameInfo.rmcpHit
    |=> !verdict.passVec[31]) else $error("rmcp pass without hit");

  cover property (verdictValid && verdict.toMgmtController);
  cover property (verdictValid && verdict.v4WakeHit);
  cover property (verdictValid && verdict.passVec[31]);
endmodule

bind mpfb_filter_binding mpfb_filter_binding_chk #(
  .SHARED_ENTRIES(SHARED_ENTRIES)) chk_u (.sys_clk(sys_clk),
  .reset_n(reset_n), .regRdEn(regRdEn), .regRdValid(regRdValid),
  .frameValid(frameValid), .frameInfo(frameInfo), .verdict(verdict),
  .verdictValid(verdictValid));

// ---- sim/mpfb_rx_parser_model.sv ----
module mpfb_rx_parser_model
  import mpfb_pkg::*;
(
  // clock
  input logic sys_clk,
  // frame toward the filter
  output logic frameValid,
  output mpfb_frame_s frameInfo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frameValid = 1'b0;
    frameInfo = '0;
  end
  // fields are inverted after the pulse so a late sample cannot match
  task automatic send(input mpfb_frame_s f);
    @(negedge sys_clk);
    frameValid = 1'b1;
    frameInfo = f;
    @(negedge sys_clk);
    frameValid = 1'b0;
    frameInfo = ~f;
  endtask
endmodule

// ---- sim/mpfb_filter_binding_test.sv ----
`include "mpfb_cfg.svh"
module mpfb_filter_binding_test
  import mpfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] bnd, hit;
    logic v6;
    logic [23:0] lo;
    logic [10:0] shr, av;
    logic [31:0] dst;
    logic arp, req;
    logic [31:0] pass;
    logic [10:0] rt;
    logic wq, wk;
  } mpfb_row_s;
  logic sys_clk, reset_n, regWrEn, regRdEn, regRdValid, frameValid;
  logic verdictValid;
  logic [9:0] regPage;
  logic [6:0] regNum;
  logic [15:0] regWrData, regRdData;
  mpfb_frame_s frameInfo;
  mpfb_verdict_s verdict;
  int errorCnt = 0;
  int cmpCount = 0;
  // low24 value 0x123456, address 0x0a0b0c0d, shared enables 0x405
  mpfb_row_s rows [6] = '{
    '{32'hffffffff, 32'hbffff600, 1, 24'h123456, 11'h7ff, 11'h7ff,
      32'h0a0b0c0d, 1, 0, 32'hbffff600, 11'h405, 1, 0},
    '{32'hffffffff, 32'hbffff600, 1, 24'h123457, 11'h405, 11'h004,
      32'h0a0b0c0d, 0, 1, 32'h00002000, 11'h004, 1, 1},
    '{32'hffffffff, 32'hbffff600, 0, 24'h123456, 11'h3fa, 11'h7ff,
      32'h0a0b0c0d, 0, 0, 32'h00002000, 11'h000, 0, 1},
    '{32'h00000000, 32'hbffff600, 0, 24'h000000, 11'h401, 11'h401,
      32'h0d0c0b0a, 1, 1, 32'hbffff600, 11'h401, 0, 0},
    '{32'h00000600, 32'hbffff600, 1, 24'h654321, 11'h000, 11'h7ff,
      32'h0a0b0c0c, 0, 1, 32'hbffff000, 11'h000, 0, 0},
    '{32'h10001000, 32'h10001000, 1, 24'h000000, 11'h7ff, 11'h000,
      32'h0a0b0c0d, 0, 0, 32'h00000000, 11'h000, 0, 1}};

  always #25 sys_clk = ~sys_clk;

  mpfb_filter_binding dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .regPage(regPage), .regNum(regNum), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .frameValid(frameValid),
    .frameInfo(frameInfo), .verdict(verdict), .verdictValid(verdictValid));
  mpfb_rx_parser_model src_u (.sys_clk(sys_clk), .frameValid(frameValid),
    .frameInfo(frameInfo));

  function automatic mpfb_frame_s mk(input mpfb_row_s r);
    return {r.hit[9], r.hit[10], r.hit[12], r.hit[13], r.hit[14],
      r.hit[15], r.hit[27:16], r.hit[28],
      r.hit[29], r.hit[31], r.v6, r.lo, r.shr, r.av, r.arp, r.req, r.dst};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmpCount++;
    if (g !== e) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] n, input logic [15:0] d);
    @(negedge sys_clk);
    regNum = n;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rdc(input logic [6:0] n, input logic [15:0] e);
    @(negedge sys_clk);
    regNum = n;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    chk("rdvalid", 1, regRdValid);
    chk("rddata", e, regRdData);
  endtask
  task automatic wrapUp;
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    regPage = `MPFB_PAGE;
    regNum = 7'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 16'h0000;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    rdc(`MPFB_REG_BIND_HI, 16'h0000);
    rdc(`MPFB_REG_SHR_EN, `MPFB_SHR_EN_RST);
    wr(`MPFB_REG_LOW24_LO, 16'h3456);
    wr(`MPFB_REG_LOW24_HI, 16'h0012);
    wr(`MPFB_REG_V4_LO, 16'h0c0d);
    wr(`MPFB_REG_V4_HI, 16'h0a0b);
    wr(`MPFB_REG_SHR_EN, 16'hffff);
    rdc(`MPFB_REG_SHR_EN, 16'h07ff);
    wr(`MPFB_REG_SHR_EN, 16'h0405);
    rdc(`MPFB_REG_V4_HI, 16'h0a0b);
    rdc(`MPFB_REG_LOW24_HI, 16'h0012);
    rdc(`MPFB_REG_LOW24_LO, 16'h3456);
    foreach (rows[i]) begin
      wr(`MPFB_REG_BIND_LO, rows[i].bnd[15:0]);
      wr(`MPFB_REG_BIND_HI, rows[i].bnd[31:16]);
      src_u.send(mk(rows[i]));
      chk("valid", 1, verdictValid);
      chk("pass", rows[i].pass, verdict.passVec);
      chk("route", rows[i].rt, verdict.sharedAddrRoute);
      chk("mgmt", |rows[i].rt, verdict.toMgmtController);
      chk("v4req", rows[i].wq, verdict.v4RequestHit);
      chk("v4wake", rows[i].wk, verdict.v4WakeHit);
    end
    wr(`MPFB_REG_BIND_LO, 16'hffff);
    wr(`MPFB_REG_BIND_HI, 16'hffff);
    rdc(`MPFB_REG_BIND_LO, 16'hd600);
    rdc(`MPFB_REG_BIND_HI, 16'hbfff);
    rdc(7'h35, 16'h0000);
    regPage = 10'h320;
    wr(`MPFB_REG_SHR_EN, 16'h0000);
    regPage = `MPFB_PAGE;
    rdc(`MPFB_REG_SHR_EN, 16'h0405);
    // leave a non-zero verdict behind so the reset checks can trip
    src_u.send(mk(rows[0]));
    chk("pass", rows[0].pass, verdict.passVec);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("rstpass", 0, verdict.passVec);
    chk("rstroute", 0, verdict.sharedAddrRoute);
    reset_n = 1'b1;
    rdc(`MPFB_REG_V4_LO, 16'h0000);
    wrapUp;
  end

  // the run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errorCnt++;
    wrapUp;
  end
endmodule
